// [core/tmoa_core.sv]
// Conversion sequencer, limit registers and overtemperature alarm
//
// Local design decisions: the register addresses and the address-and-strobe port.
`default_nettype none

module tmoa_core #(
    parameter int unsigned CONV_CYC = tmoa_pkg::CONV_PERIOD_CYC
) (
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    // Register port
    input  wire logic [tmoa_pkg::REG_AW-1:0] addr_i,
    input  wire logic [tmoa_pkg::REG_DW-1:0] wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [tmoa_pkg::REG_DW-1:0] rdata_o,
    // Converter link
    output logic                             conv_start_o,
    input  wire logic                        sens_clk_i,
    input  wire logic                        sens_dat_i,
    output logic                             temp_valid_o,
    // Alarm pin, open drain
    output logic                             overtemp_alarm_out_o,
    output logic                             overtemp_alarm_out_oe_n_o,
    // Address straps
    input  wire logic                        addr_strap_2_i,
    input  wire logic                        addr_strap_1_i,
    input  wire logic                        addr_strap_0_i,
    output logic      [6:0]                  bus_addr_o
);
    import tmoa_pkg::*;

    function automatic logic [2:0] fq_need(input logic [1:0] code);
        case (code)
            2'h0:    fq_need = FQ_N0;
            2'h1:    fq_need = FQ_N1;
            2'h2:    fq_need = FQ_N2;
            default: fq_need = FQ_N3;
        endcase
    endfunction : fq_need

    function automatic logic sgt(input logic [LIM_W-1:0] a,
                                 input logic [LIM_W-1:0] b);
        sgt = $signed(a) > $signed(b);
    endfunction : sgt

    tmoa_state_e       state;
    tmoa_state_e       next_state;
    logic [7:0]        conf;
    logic [LIM_W-1:0]  tos;
    logic [LIM_W-1:0]  thyst;
    logic [TEMP_W-1:0] temp;
    logic [TEMP_W-1:0] shift;
    logic [3:0]        bit_cnt;
    logic [PCNT_W-1:0] period_cnt;
    logic              sclk_s1;
    logic              sclk_s2;
    logic              sclk_s3;
    logic              sdat_s1;
    logic              sdat_s2;
    logic [2:0]        strap_s1;
    logic [2:0]        strap_s2;
    logic              alarm_act;
    logic              hyst_phase;
    logic [2:0]        fcnt;

    logic              sclk_rise;
    logic              conv_done;
    logic [TEMP_W-1:0] temp_new;
    logic [LIM_W-1:0]  cmp_val;
    logic              wr_conf;
    logic              mode_chg;
    logic              int_mode;
    logic              shdn_req;
    logic              wake_req;
    logic              period_end;
    logic              above;
    logic              below;
    logic              fault;
    logic              trip;
    logic [2:0]        need;
    logic [2:0]        fcnt_inc;

    // Two-stage synchronisers for the converter link and the address straps
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sclk_s1  <= 1'b0;
            sclk_s2  <= 1'b0;
            sclk_s3  <= 1'b0;
            sdat_s1  <= 1'b0;
            sdat_s2  <= 1'b0;
            strap_s1 <= 3'h0;
            strap_s2 <= 3'h0;
        end else begin
            sclk_s1  <= sens_clk_i;
            sclk_s2  <= sclk_s1;
            sclk_s3  <= sclk_s2;
            sdat_s1  <= sens_dat_i;
            sdat_s2  <= sdat_s1;
            strap_s1 <= {addr_strap_2_i, addr_strap_1_i, addr_strap_0_i};
            strap_s2 <= strap_s1;
        end
    end

    assign sclk_rise = sclk_s2 & ~sclk_s3;
    assign temp_new  = {shift[TEMP_W-2:0], sdat_s2};
    assign cmp_val   = temp_new[TEMP_W-1:CMP_LSB];
    assign conv_done = (state == TMOA_CONV) && sclk_rise
                       && (bit_cnt == BIT_LAST);
    assign wr_conf   = wr_i && (addr_i == ADDR_CONF);
    assign mode_chg  = wr_conf && (wdata_i[CONF_MODE] != conf[CONF_MODE]);
    assign int_mode  = conf[CONF_MODE];
    assign shdn_req  = wr_conf && wdata_i[CONF_SHDN];
    assign wake_req  = wr_conf && !wdata_i[CONF_SHDN] && conf[CONF_SHDN];
    assign period_end = period_cnt == PCNT_W'(CONV_CYC - 1);

    assign bus_addr_o = {BUS_ADDR_HI, strap_s2};
    assign conv_start_o = state == TMOA_START;
    assign overtemp_alarm_out_o = 1'b0;

    // Sequencer
    always_comb begin
        next_state = state;
        case (state)
            TMOA_OFF:   if (wake_req) next_state = TMOA_START;
            TMOA_START: next_state = TMOA_CONV;
            TMOA_CONV:  if (conv_done) next_state = TMOA_WAIT;
            TMOA_WAIT:  if (period_end) next_state = TMOA_START;
            default:    next_state = TMOA_OFF;
        endcase
        if (shdn_req) begin
            next_state = TMOA_OFF;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= TMOA_START;
        end else begin
            state <= next_state;
        end
    end

    // 100 ms period timer, held at its end value
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            period_cnt <= '0;
        end else if (state == TMOA_START) begin
            // The start cycle itself is the first cycle of the period
            period_cnt <= PCNT_W'(1);
        end else if (!period_end) begin
            period_cnt <= PCNT_W'(period_cnt + 1'b1);
        end
    end

    // Serial result from the converter, MSB first
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            shift   <= '0;
            bit_cnt <= 4'h0;
        end else if (state == TMOA_START) begin
            bit_cnt <= 4'h0;
        end else if (state == TMOA_CONV && sclk_rise) begin
            shift   <= temp_new;
            bit_cnt <= 4'(bit_cnt + 4'h1);
        end
    end

    // eleven-bit result stored; valid after first
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            temp         <= '0;
            temp_valid_o <= 1'b0;
        end else if (conv_done) begin
            temp         <= temp_new;
            temp_valid_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            conf  <= CONF_RST;
            tos   <= TOS_RST;
            thyst <= THYST_RST;
        end else if (wr_i) begin
            case (addr_i)
                ADDR_CONF:  conf  <= wdata_i[CONF_W-1:0];
                ADDR_THYST: thyst <= wdata_i[REG_DW-1:LIM_PAD];
                ADDR_TOS:   tos   <= wdata_i[REG_DW-1:LIM_PAD];
                default:    ;
            endcase
        end
    end

    // read data one cycle later, no side effect on conversion
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            case (addr_i)
                ADDR_TEMP:  rdata_o <= {temp, TEMP_PAD'(0)};
                ADDR_CONF:  rdata_o <= {8'h00, conf};
                ADDR_THYST: rdata_o <= {thyst, LIM_PAD'(0)};
                default:    rdata_o <= {tos, LIM_PAD'(0)};
            endcase
        end
    end

    // both limits judged on each new reading
    assign above = sgt(cmp_val, tos);
    assign below = sgt(thyst, cmp_val);
    assign need  = fq_need(conf[CONF_FQHI:CONF_FQLO]);
    assign fcnt_inc = 3'(fcnt + 3'h1);

    // comparator swaps limit; interrupt phase picks limit
    always_comb begin
        if (int_mode) begin
            fault = !alarm_act && (hyst_phase ? below : above);
        end else begin
            fault = alarm_act ? below : above;
        end
    end

    // fault run must reach programmed length
    assign trip = conv_done && fault && (fcnt_inc >= need);

    // any non-fault reading restarts the run
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fcnt <= 3'h0;
        end else if (mode_chg || trip) begin
            fcnt <= 3'h0;
        end else if (conv_done) begin
            fcnt <= fault ? fcnt_inc : 3'h0;
        end
    end

    // mode change restarts alarm state; new trip beats read clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            alarm_act  <= 1'b0;
            hyst_phase <= 1'b0;
        end else if (mode_chg) begin
            alarm_act  <= 1'b0;
            hyst_phase <= 1'b0;
        end else if (trip) begin
            alarm_act  <= int_mode ? 1'b1 : !alarm_act;
        end else if (int_mode && rd_i && alarm_act) begin
            // after any cleared trip, wait for hysteresis
            alarm_act  <= 1'b0;
            hyst_phase <= 1'b1;
        end
    end

    // polarity; released pin reads high through pull-up
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            overtemp_alarm_out_oe_n_o <= 1'b1;
        end else begin
            overtemp_alarm_out_oe_n_o <= conf[CONF_POL] ? alarm_act
                                                        : !alarm_act;
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_leave_shdn;
        wr_conf && conf[CONF_SHDN] && !wdata_i[CONF_SHDN];
    endsequence

    sequence s_start_then_conv;
        conv_start_o ##1 (state == TMOA_CONV);
    endsequence

    temp_read_data_a: assert property (
        rd_i && addr_i == ADDR_TEMP && !conv_done
        |=> rdata_o == {$past(temp), TEMP_PAD'(0)})
        else $error("temperature read data wrong");

    temp_update_a: assert property (
        conv_done |=> temp == $past(temp_new) && temp_valid_o)
        else $error("reading not stored at conversion end");

    shdn_halt_a: assert property (
        conf[CONF_SHDN] && !wr_i |-> !conv_start_o && state == TMOA_OFF)
        else $error("conversion while in shutdown");

    wake_start_a: assert property (
        s_leave_shdn |=> s_start_then_conv)
        else $error("no conversion after leaving shutdown");

    start_spacing_a: assert property (
        conv_start_o |=> !conv_start_o [*8])
        else $error("conversion restarted too soon");

    comp_set_a: assert property (
        conv_done && !int_mode && !alarm_act && above && need == FQ_N0
        && !mode_chg |=> alarm_act)
        else $error("comparator alarm not asserted above limit");

    comp_hold_a: assert property (
        !int_mode && !conv_done && !mode_chg
        |=> alarm_act == $past(alarm_act))
        else $error("comparator alarm changed without conversion");

    int_clear_a: assert property (
        int_mode && alarm_act && rd_i && !trip && !mode_chg
        |=> !alarm_act && hyst_phase)
        else $error("interrupt alarm not cleared by read");

    fault_filter_a: assert property (
        conv_done && fcnt_inc < need && !mode_chg && !(int_mode && rd_i)
        |=> alarm_act == $past(alarm_act))
        else $error("alarm moved before fault run complete");

    pin_level_a: assert property (
        ##1 overtemp_alarm_out_oe_n_o ==
        ($past(conf[CONF_POL]) ? $past(alarm_act) : !$past(alarm_act)))
        else $error("alarm pin level wrong");

    addr_fixed_a: assert property (
        bus_addr_o[6:3] == BUS_ADDR_HI)
        else $error("bus address high bits wrong");

    // Start-to-start spacing, counted apart from the sequencer's timer
    logic [PCNT_W-1:0] since_start;
    logic              fresh_start;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            since_start <= '0;
            fresh_start <= 1'b1;
        end else if (conv_start_o) begin
            since_start <= PCNT_W'(1);
            fresh_start <= 1'b0;
        end else begin
            if (since_start != '1) begin
                since_start <= PCNT_W'(since_start + 1'b1);
            end
            // A start after shutdown begins a new spacing
            if (state == TMOA_OFF) begin
                fresh_start <= 1'b1;
            end
        end
    end

    period_len_a: assert property (
        conv_start_o && !fresh_start |-> since_start == PCNT_W'(CONV_CYC))
        else $error("conversion period wrong");

    strap_addr_a: assert property (
        ##1 bus_addr_o[2:0] == $past(strap_s1))
        else $error("strap bits not in bus address");

    first_valid_a: assert property (
        !temp_valid_o && !conv_done |=> !temp_valid_o)
        else $error("reading marked valid before conversion");

    run_clear_a: assert property (
        conv_done && !fault |=> fcnt == 3'h0)
        else $error("fault run not restarted");

    comp_clear_a: assert property (
        conv_done && !int_mode && alarm_act && below && need == FQ_N0
        && !mode_chg |=> !alarm_act)
        else $error("comparator alarm not released below limit");

    int_first_a: assert property (
        int_mode && !hyst_phase && !alarm_act && conv_done && !above
        && !mode_chg |=> !alarm_act)
        else $error("interrupt alarm set without first trip");

    int_rearm_a: assert property (
        int_mode && hyst_phase && !alarm_act && conv_done && !below
        && !mode_chg |=> !alarm_act)
        else $error("interrupt alarm set without hysteresis trip");

endmodule : tmoa_core

`default_nettype wire

// [core/tmoa_pkg.sv]
// Constants, register map and types of the temperature monitor with alarm
`default_nettype none

package tmoa_pkg;

    // Register port
    localparam int unsigned REG_AW     = 2;
    localparam int unsigned REG_DW     = 16;
    localparam logic [1:0]  ADDR_TEMP  = 2'h0;
    localparam logic [1:0]  ADDR_CONF  = 2'h1;
    localparam logic [1:0]  ADDR_THYST = 2'h2;
    localparam logic [1:0]  ADDR_TOS   = 2'h3;

    // Field widths and placement inside the 16-bit words
    localparam int unsigned TEMP_W   = 11;
    localparam int unsigned LIM_W    = 9;
    localparam int unsigned CONF_W   = 8;
    localparam int unsigned TEMP_PAD = REG_DW - TEMP_W;
    localparam int unsigned LIM_PAD  = REG_DW - LIM_W;
    localparam int unsigned CMP_LSB  = TEMP_W - LIM_W;

    // Configuration bits
    localparam int unsigned CONF_SHDN = 0;
    localparam int unsigned CONF_MODE = 1;
    localparam int unsigned CONF_POL  = 2;
    localparam int unsigned CONF_FQLO = 3;
    localparam int unsigned CONF_FQHI = 4;

    // Reset values; limits carry 0.5 C per step
    localparam logic [7:0] CONF_RST  = 8'h00;
    localparam logic [8:0] TOS_RST   = 9'h0A0;
    localparam logic [8:0] THYST_RST = 9'h096;

    // Fault run lengths per code
    localparam logic [2:0] FQ_N0 = 3'h1;
    localparam logic [2:0] FQ_N1 = 3'h2;
    localparam logic [2:0] FQ_N2 = 3'h4;
    localparam logic [2:0] FQ_N3 = 3'h6;

    // Fixed upper part of the bus address
    localparam logic [3:0] BUS_ADDR_HI = 4'h9;

    // Timing
    localparam int unsigned CLK_PERIOD_NS  = 5;
    localparam int unsigned CONV_PERIOD_MS = 100;
    localparam int unsigned CONV_PERIOD_CYC =
        CONV_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned PCNT_W = 25;
    localparam logic [3:0]  BIT_LAST = 4'(TEMP_W - 1);

    typedef enum logic [1:0] {
        TMOA_OFF,
        TMOA_START,
        TMOA_CONV,
        TMOA_WAIT
    } tmoa_state_e;

endpackage : tmoa_pkg

`default_nettype wire

// [verif/tmoa_sens_model.sv]
// Behavioural converter that answers the sequencer over the serial link
`default_nettype none

module tmoa_sens_model #(
    parameter int unsigned HALF_NS = 40
) (
    // Request side
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        conv_start_i,
    input  wire logic [10:0] temp_i,
    input  wire logic        slow_i,
    // Serial link
    output logic             sens_clk_o,
    output logic             sens_dat_o,
    output logic             busy_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sens_clk_o = 1'b0;
        sens_dat_o = 1'b1;
        busy_o     = 1'b0;
        forever begin
            @(posedge clk_i);
            if (rst_n_i === 1'b1 && conv_start_i === 1'b1) begin
                busy_o = 1'b1;
                // Odd offset keeps the link out of phase with the core clock
                #3;
                // A slow converter takes longer before its first bit
                if (slow_i) #(4 * HALF_NS);
                for (int i = 10; i >= 0; i--) begin
                    sens_dat_o = temp_i[i];
                    #(HALF_NS);
                    sens_clk_o = 1'b1;
                    #(HALF_NS);
                    sens_clk_o = 1'b0;
                end
                // Data no longer held: show the opposite of the last bit
                sens_dat_o = ~temp_i[0];
                busy_o     = 1'b0;
            end
        end
    end

endmodule : tmoa_sens_model

`default_nettype wire

// [verif/tb_tmoa_core.sv]
// Self-checking bench of the temperature monitor with alarm
`default_nettype none

module tb_tmoa_core;
    timeunit 1ns;
    timeprecision 100ps;
    import tmoa_pkg::*;

    localparam int unsigned CC   = 600;
    localparam logic [10:0] HOT  = 11'h288;
    localparam logic [10:0] MID  = 11'h283;
    localparam logic [10:0] COLD = 11'h738;

    logic        clk_i, rst_n_i, wr_i, rd_i, slow, busy, rd_seen;
    logic [1:0]  addr_i;
    logic [15:0] wdata_i, rdata_o;
    logic [10:0] mtemp, last_t;
    logic [2:0]  strap;
    logic        conv_start_o, sens_clk, sens_dat, temp_valid_o;
    logic        alarm_o, oe_n;
    logic [6:0]  bus_addr_o;
    wire logic   pin;
    logic [15:0] exp_q[$];
    int          failures, checks, cyc, n, gap, last_gap;
    integer      seed = 32'h17a536cc;

    // Released pin is pulled up
    assign pin = oe_n ? 1'b1 : alarm_o;

    tmoa_core #(.CONV_CYC(CC)) u_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .conv_start_o(conv_start_o), .sens_clk_i(sens_clk),
        .sens_dat_i(sens_dat), .temp_valid_o(temp_valid_o),
        .overtemp_alarm_out_o(alarm_o), .overtemp_alarm_out_oe_n_o(oe_n),
        .addr_strap_2_i(strap[2]), .addr_strap_1_i(strap[1]),
        .addr_strap_0_i(strap[0]), .bus_addr_o(bus_addr_o));

    tmoa_sens_model u_sens (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .conv_start_i(conv_start_o),
        .temp_i(mtemp), .slow_i(slow), .sens_clk_o(sens_clk),
        .sens_dat_o(sens_dat), .busy_o(busy));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    // Hang guard well above the expected run length
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures++;
            end_of_test();
        end
    end

    // Start-to-start spacing seen on the converter request
    always @(posedge clk_i) begin
        gap <= (conv_start_o === 1'b1) ? 1 : gap + 1;
        if (conv_start_o === 1'b1) last_gap <= gap;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Read data are checked in the cycle after the strobe
    always @(posedge clk_i) rd_seen <= rd_i;
    always @(negedge clk_i) begin
        if (rd_seen === 1'b1) begin
            chk(rdata_o, exp_q.pop_front());
        end
    end

    task automatic rd(input logic [1:0] a, input logic [15:0] e);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        exp_q.push_back(e);
        @(posedge clk_i);
        rd_i   <= 1'b0;
    endtask : rd

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : wr

    task automatic pck(input logic e);
        repeat (3) @(negedge clk_i);
        chk(16'(pin), 16'(e));
    endtask : pck

    // Reads are optional: in interrupt mode any read clears the alarm
    task automatic go(input logic [10:0] t, input logic q);
        repeat (1000) if (conv_start_o !== 1'b1) @(negedge clk_i);
        repeat (20) @(negedge clk_i);
        if (q) rd(ADDR_TEMP, {last_t, 5'h00});
        repeat (1000) if (busy !== 1'b0) @(negedge clk_i);
        repeat (8) @(negedge clk_i);
        last_t = t;
        if (q) rd(ADDR_TEMP, {t, 5'h00});
    endtask : go

    task automatic conv(input logic [10:0] t, input logic q);
        @(posedge clk_i);
        mtemp <= t;
        slow  <= 1'($random(seed));
        go(t, q);
    endtask : conv

    initial begin
        logic [15:0] w;
        int          nq[4] = '{1, 2, 4, 6};
        rst_n_i = 1'b0;
        wr_i    = 1'b0;
        rd_i    = 1'b0;
        addr_i  = 2'h0;
        wdata_i = 16'h0000;
        mtemp   = 11'h190;
        last_t  = 11'h000;
        slow    = 1'b0;
        strap   = 3'($random(seed));
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(negedge clk_i);
        chk(16'(temp_valid_o), 16'h0000);
        chk(16'(pin), 16'h0001);
        go(11'h190, 1'b1);
        // Straps pass two synchroniser stages after reset
        chk(16'(bus_addr_o), {9'h000, BUS_ADDR_HI, strap});
        chk(16'(bus_addr_o[2:0]), 16'(strap));
        chk(16'(temp_valid_o), 16'h0001);
        rd(ADDR_CONF, 16'h0000);
        rd(ADDR_THYST, 16'h4B00);
        rd(ADDR_TOS, 16'h5000);
        wr(ADDR_TEMP, 16'($random(seed)));
        rd(ADDR_TEMP, {11'h190, 5'h00});
        w = 16'($random(seed));
        wr(ADDR_TOS, w);
        rd(ADDR_TOS, {w[15:7], 7'h00});
        wr(ADDR_TOS, 16'h5000);
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_CONF, 16'(c << 3));
            rd(ADDR_CONF, 16'(c << 3));
            conv(MID, 1'b1);
            chk(16'(last_gap), 16'(CC));
            repeat (nq[c] - 1) conv(HOT, 1'b1);
            conv(MID, 1'b1);
            for (int i = 0; i < nq[c]; i++) begin
                conv(HOT, 1'b1);
                chk(16'(pin), 16'(i != nq[c] - 1));
            end
            for (int i = 0; i < nq[c]; i++) begin
                conv(COLD, 1'b1);
                chk(16'(pin), 16'(i == nq[c] - 1));
            end
        end
        wr(ADDR_CONF, 16'h0004);
        pck(1'b0);
        conv(HOT, 1'b1);
        pck(1'b1);
        wr(ADDR_CONF, 16'h0000);
        pck(1'b0);
        wr(ADDR_CONF, 16'h0001);
        rd(ADDR_CONF, 16'h0001);
        n = 0;
        repeat (2 * CC) begin
            @(negedge clk_i);
            if (conv_start_o === 1'b1) n++;
        end
        chk(16'(n), 16'h0000);
        pck(1'b0);
        rd(ADDR_TEMP, {HOT, 5'h00});
        @(posedge clk_i);
        mtemp <= COLD;
        wr(ADDR_CONF, 16'h0000);
        n = 0;
        repeat (4) if (conv_start_o !== 1'b1) begin
            @(negedge clk_i);
            n++;
        end
        chk(16'(n < 3), 16'h0001);
        go(COLD, 1'b1);
        pck(1'b1);
        wr(ADDR_CONF, 16'h0002);
        conv(HOT, 1'b0);
        pck(1'b0);
        conv(MID, 1'b0);
        pck(1'b0);
        rd(ADDR_CONF, 16'h0002);
        pck(1'b1);
        conv(HOT, 1'b0);
        pck(1'b1);
        conv(COLD, 1'b0);
        pck(1'b0);
        rd(ADDR_THYST, 16'h4B00);
        pck(1'b1);
        conv(COLD, 1'b0);
        pck(1'b0);
        end_of_test();
    end

endmodule : tb_tmoa_core

`default_nettype wire
